// ==== pkg/mbreq_map.vh ====
`ifndef MBREQ_MAP_VH
`define MBREQ_MAP_VH

// Function codes of the request engine.
`define MBR_FC_RD_COIL 8'h01
`define MBR_FC_RD_INPUT 8'h02
`define MBR_FC_RD_HOLD 8'h03
`define MBR_FC_RD_INREG 8'h04
`define MBR_FC_RD_EXST 8'h07
`define MBR_FC_WR_COIL 8'h05
`define MBR_FC_WR_REG 8'h06
`define MBR_FC_WR_COILS 8'h0F
`define MBR_FC_WR_REGS 8'h10
`define MBR_FC_EXC_BIT 8'h80

// Station address and element count limits.
`define MBR_SLAVE_MAX 8'hF7
`define MBR_CNT_MIN 11'h001
`define MBR_BIT_CNT_MAX 11'h7D0
`define MBR_REG_CNT_MAX 11'h07D

// Reference number windows, 484 format.
`define MBR_484_COIL_LO 20'h00001
`define MBR_484_COIL_HI 20'h003E7
`define MBR_484_INP_LO 20'h003E9
`define MBR_484_INP_HI 20'h007CF
`define MBR_484_HOLD_LO 20'h00FA1
`define MBR_484_HOLD_HI 20'h01387
`define MBR_484_INREG_LO 20'h00BB9
`define MBR_484_INREG_HI 20'h00F9F

// Reference number windows, 584/984 format, five and six digit forms.
`define MBR_984_COIL_LO 20'h00001
`define MBR_984_COIL_HI 20'h0FFFF
`define MBR_984_INP_LO 20'h02711
`define MBR_984_INP_HI 20'h04E1F
`define MBR_984_INP6_LO 20'h186A1
`define MBR_984_INP6_HI 20'h2869F
`define MBR_984_HOLD_LO 20'h09C41
`define MBR_984_HOLD_HI 20'h0C34F
`define MBR_984_HOLD6_LO 20'h61A81
`define MBR_984_HOLD6_HI 20'h71A7F
`define MBR_984_INREG_LO 20'h07531
`define MBR_984_INREG_HI 20'h09C3F
`define MBR_984_INREG6_LO 20'h493E1
`define MBR_984_INREG6_HI 20'h593DF
`define MBR_NO_RANGE_LO 20'hFFFFF
`define MBR_NO_RANGE_HI 20'h00000

// Single coil payloads.
`define MBR_COIL_ON 16'hFF00
`define MBR_COIL_OFF 16'h0000

// Timing.
`define MBR_CLK_KHZ 40000
`define MBR_RSP_TIMEOUT_MS 1000
`define MBR_RSP_TIMEOUT_CYC (`MBR_CLK_KHZ * `MBR_RSP_TIMEOUT_MS)

// Transmit FIFO shape.
`define MBR_FIFO_WIDTH 9
`define MBR_FIFO_DEPTH 8

`endif

// ==== hw/mbreq_fifo.v ====
`timescale 1ns/1ps
`default_nettype none

module mbreq_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side, registered head
  output reg out_valid_reg,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data_reg
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  localparam [AW:0] FULL = DEPTH;

  assign in_ready = (count_reg != FULL);
  assign push = in_valid && in_ready;
  // The head register reloads whenever memory holds a word and the head is empty or being drained.
  assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_reg <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/mbreq_master.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mbreq_map.vh"

module mbreq_master #(
  parameter RSP_TIMEOUT_CYC = `MBR_RSP_TIMEOUT_CYC
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Request from the control program
  input wire req_valid,
  input wire req_is_write,
  input wire [7:0] req_slave,
  input wire [7:0] req_func,
  input wire req_fmt_484,
  input wire [19:0] req_slave_ref,
  input wire [15:0] req_master_addr,
  input wire [10:0] req_count,
  input wire [15:0] req_exc_addr,
  // Status flags
  output reg port_busy_flag_reg,
  output reg port_comm_error_flag_reg,
  // Request bytes toward the serial framer
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  output wire tx_last,
  // Reply bytes from the serial framer
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_last,
  input wire rsp_error,
  // Master memory port
  output reg mem_rd_reg,
  output reg mem_wr_reg,
  output reg [15:0] mem_addr_reg,
  output reg [15:0] mem_wdata_reg,
  input wire [15:0] mem_rd_data
);

  localparam S_IDLE = 4'h0;
  localparam S_HDR = 4'h1;
  localparam S_FETCH = 4'h2;
  localparam S_FWAIT = 4'h3;
  localparam S_PHI = 4'h4;
  localparam S_PLO = 4'h5;
  localparam S_PBYTE = 4'h6;
  localparam S_RECV = 4'h7;
  localparam S_UNPK = 4'h8;
  localparam [25:0] TIMEOUT_LAST = RSP_TIMEOUT_CYC - 1;

  reg [3:0] state_reg;
  reg [7:0] slave_reg;
  reg [7:0] func_reg;
  reg write_reg;
  reg bits_reg;
  reg [15:0] paddr_reg;
  reg [10:0] cnt_reg;
  reg [10:0] rem_reg;
  reg [15:0] mptr_reg;
  reg [15:0] exc_reg;
  reg [2:0] idx_reg;
  reg [2:0] bit_reg;
  reg [7:0] acc_reg;
  reg [15:0] word_reg;
  reg [8:0] ridx_reg;
  reg [7:0] rbyte_reg;
  reg exc_seen_reg;
  reg bad_reg;
  reg last_seen_reg;
  reg [25:0] timer_reg;

  // Request check and address mapping.
  reg fc_ok;
  reg cnt_used;
  reg no_addr;
  reg is_bit;
  reg [19:0] lo1;
  reg [19:0] hi1;
  reg [19:0] lo2;
  reg [19:0] hi2;
  reg in1;
  reg in2;
  reg cnt_ok;
  reg req_ok;
  reg [15:0] paddr_next;
  reg [19:0] paddr_diff;

  always @* begin
    fc_ok = 1'b0;
    cnt_used = 1'b0;
    no_addr = 1'b0;
    is_bit = 1'b0;
    lo1 = `MBR_NO_RANGE_LO;
    hi1 = `MBR_NO_RANGE_HI;
    lo2 = `MBR_NO_RANGE_LO;
    hi2 = `MBR_NO_RANGE_HI;
    if (!req_is_write) begin
      if (req_func == `MBR_FC_RD_COIL) begin
        fc_ok = 1'b1;
        cnt_used = 1'b1;
        is_bit = 1'b1;
        lo1 = req_fmt_484 ? `MBR_484_COIL_LO : `MBR_984_COIL_LO;
        hi1 = req_fmt_484 ? `MBR_484_COIL_HI : `MBR_984_COIL_HI;
      end else if (req_func == `MBR_FC_RD_INPUT) begin
        fc_ok = 1'b1;
        cnt_used = 1'b1;
        is_bit = 1'b1;
        lo1 = req_fmt_484 ? `MBR_484_INP_LO : `MBR_984_INP_LO;
        hi1 = req_fmt_484 ? `MBR_484_INP_HI : `MBR_984_INP_HI;
        lo2 = req_fmt_484 ? `MBR_NO_RANGE_LO : `MBR_984_INP6_LO;
        hi2 = req_fmt_484 ? `MBR_NO_RANGE_HI : `MBR_984_INP6_HI;
      end else if (req_func == `MBR_FC_RD_HOLD) begin
        fc_ok = 1'b1;
        cnt_used = 1'b1;
        lo1 = req_fmt_484 ? `MBR_484_HOLD_LO : `MBR_984_HOLD_LO;
        hi1 = req_fmt_484 ? `MBR_484_HOLD_HI : `MBR_984_HOLD_HI;
        lo2 = req_fmt_484 ? `MBR_NO_RANGE_LO : `MBR_984_HOLD6_LO;
        hi2 = req_fmt_484 ? `MBR_NO_RANGE_HI : `MBR_984_HOLD6_HI;
      end else if (req_func == `MBR_FC_RD_INREG) begin
        fc_ok = 1'b1;
        cnt_used = 1'b1;
        lo1 = req_fmt_484 ? `MBR_484_INREG_LO : `MBR_984_INREG_LO;
        hi1 = req_fmt_484 ? `MBR_484_INREG_HI : `MBR_984_INREG_HI;
        lo2 = req_fmt_484 ? `MBR_NO_RANGE_LO : `MBR_984_INREG6_LO;
        hi2 = req_fmt_484 ? `MBR_NO_RANGE_HI : `MBR_984_INREG6_HI;
      end else if (req_func == `MBR_FC_RD_EXST) begin
        fc_ok = 1'b1;
        no_addr = 1'b1;
      end
    end else begin
      if (req_func == `MBR_FC_WR_COIL || req_func == `MBR_FC_WR_COILS) begin
        fc_ok = 1'b1;
        cnt_used = (req_func == `MBR_FC_WR_COILS);
        is_bit = 1'b1;
        lo1 = req_fmt_484 ? `MBR_484_COIL_LO : `MBR_984_COIL_LO;
        hi1 = req_fmt_484 ? `MBR_484_COIL_HI : `MBR_984_COIL_HI;
      end else if (req_func == `MBR_FC_WR_REG || req_func == `MBR_FC_WR_REGS) begin
        fc_ok = 1'b1;
        cnt_used = (req_func == `MBR_FC_WR_REGS);
        lo1 = req_fmt_484 ? `MBR_484_HOLD_LO : `MBR_984_HOLD_LO;
        hi1 = req_fmt_484 ? `MBR_484_HOLD_HI : `MBR_984_HOLD_HI;
        lo2 = req_fmt_484 ? `MBR_NO_RANGE_LO : `MBR_984_HOLD6_LO;
        hi2 = req_fmt_484 ? `MBR_NO_RANGE_HI : `MBR_984_HOLD6_HI;
      end
    end
    in1 = (req_slave_ref >= lo1) && (req_slave_ref <= hi1);
    in2 = (req_slave_ref >= lo2) && (req_slave_ref <= hi2);
    paddr_diff = in1 ? (req_slave_ref - lo1) : (req_slave_ref - lo2);
    paddr_next = paddr_diff[15:0];
    cnt_ok = (req_count >= `MBR_CNT_MIN) &&
      (req_count <= (is_bit ? `MBR_BIT_CNT_MAX : `MBR_REG_CNT_MAX));
    req_ok = (req_slave <= `MBR_SLAVE_MAX) && fc_ok && (no_addr || in1 || in2) &&
      (!cnt_used || cnt_ok);
  end

  // Request frame byte selection.
  reg [2:0] hlen_last;
  reg [7:0] hdr_byte;
  reg [7:0] byte_cnt;
  reg f_in_valid;
  reg [7:0] f_in_data;
  reg f_in_last;
  wire f_in_ready;
  wire f_push;
  wire [10:0] bc_bits = (cnt_reg + 11'h007) >> 3;
  wire [10:0] bc_regs = {cnt_reg[9:0], 1'b0};

  always @* begin
    if (func_reg == `MBR_FC_RD_EXST) begin
      hlen_last = 3'h1;
    end else if (!write_reg) begin
      hlen_last = 3'h5;
    end else if (func_reg == `MBR_FC_WR_COIL || func_reg == `MBR_FC_WR_REG) begin
      hlen_last = 3'h3;
    end else begin
      hlen_last = 3'h6;
    end
    byte_cnt = bits_reg ? bc_bits[7:0] : bc_regs[7:0];
    case (idx_reg)
      3'h0: hdr_byte = slave_reg;
      3'h1: hdr_byte = func_reg;
      3'h2: hdr_byte = paddr_reg[15:8];
      3'h3: hdr_byte = paddr_reg[7:0];
      3'h4: hdr_byte = {5'h00, cnt_reg[10:8]};
      3'h5: hdr_byte = cnt_reg[7:0];
      default: hdr_byte = byte_cnt;
    endcase
    f_in_valid = 1'b0;
    f_in_data = hdr_byte;
    f_in_last = 1'b0;
    case (state_reg)
      S_HDR: begin
        f_in_valid = 1'b1;
        f_in_last = (idx_reg == hlen_last) && !write_reg;
      end
      S_PHI: begin
        f_in_valid = 1'b1;
        f_in_data = word_reg[15:8];
      end
      S_PLO: begin
        f_in_valid = 1'b1;
        f_in_data = word_reg[7:0];
        f_in_last = (rem_reg == 11'h000);
      end
      S_PBYTE: begin
        f_in_valid = 1'b1;
        f_in_data = acc_reg;
        f_in_last = (rem_reg == 11'h000);
      end
      default: begin
        f_in_valid = 1'b0;
      end
    endcase
  end

  assign f_push = f_in_valid && f_in_ready;

  wire [8:0] f_out_data;

  mbreq_fifo #(
    .WIDTH(`MBR_FIFO_WIDTH),
    .DEPTH(`MBR_FIFO_DEPTH),
    .AW(3)
  ) u_tx_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({f_in_last, f_in_data}),
    .out_valid_reg(tx_valid),
    .out_ready(tx_ready),
    .out_data_reg(f_out_data)
  );

  assign tx_data = f_out_data[7:0];
  assign tx_last = f_out_data[8];

  wire rd_data_mode = !write_reg && !exc_seen_reg && (func_reg != `MBR_FC_RD_EXST);
  wire word_store = rsp_valid && (ridx_reg >= 9'h003) && rd_data_mode && !bad_reg &&
    !bits_reg && !ridx_reg[0];
  wire finish_err = bad_reg || (rem_reg > {10'h000, word_store});

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      slave_reg <= 8'h00;
      func_reg <= 8'h00;
      write_reg <= 1'b0;
      bits_reg <= 1'b0;
      paddr_reg <= 16'h0000;
      cnt_reg <= 11'h000;
      rem_reg <= 11'h000;
      mptr_reg <= 16'h0000;
      exc_reg <= 16'h0000;
      idx_reg <= 3'h0;
      bit_reg <= 3'h0;
      acc_reg <= 8'h00;
      word_reg <= 16'h0000;
      ridx_reg <= 9'h000;
      rbyte_reg <= 8'h00;
      exc_seen_reg <= 1'b0;
      bad_reg <= 1'b0;
      last_seen_reg <= 1'b0;
      timer_reg <= 26'h0000000;
      port_busy_flag_reg <= 1'b0;
      port_comm_error_flag_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 16'h0000;
    end else begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_valid && req_ok) begin
            state_reg <= S_HDR;
            port_busy_flag_reg <= 1'b1;
            port_comm_error_flag_reg <= 1'b0;
            slave_reg <= req_slave;
            func_reg <= req_func;
            write_reg <= req_is_write;
            bits_reg <= is_bit;
            paddr_reg <= paddr_next;
            cnt_reg <= cnt_used ? req_count : 11'h001;
            rem_reg <= (req_func == `MBR_FC_RD_EXST) ? 11'h000 :
              (cnt_used ? req_count : 11'h001);
            mptr_reg <= req_master_addr;
            exc_reg <= req_exc_addr;
            idx_reg <= 3'h0;
            bit_reg <= 3'h0;
            acc_reg <= 8'h00;
            ridx_reg <= 9'h000;
            exc_seen_reg <= 1'b0;
            bad_reg <= 1'b0;
            last_seen_reg <= 1'b0;
          end
        end
        S_HDR: begin
          if (f_push) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == hlen_last) begin
              if (write_reg) begin
                state_reg <= S_FETCH;
              end else begin
                state_reg <= S_RECV;
                timer_reg <= 26'h0000000;
              end
            end
          end
        end
        S_FETCH: begin
          mem_rd_reg <= 1'b1;
          mem_addr_reg <= mptr_reg;
          state_reg <= S_FWAIT;
        end
        S_FWAIT: begin
          mptr_reg <= mptr_reg + 16'h0001;
          rem_reg <= rem_reg - 11'h001;
          if (func_reg == `MBR_FC_WR_COILS) begin
            acc_reg[bit_reg] <= mem_rd_data[0];
            bit_reg <= bit_reg + 3'h1;
            state_reg <= (bit_reg == 3'h7 || rem_reg == 11'h001) ? S_PBYTE : S_FETCH;
          end else begin
            word_reg <= (func_reg != `MBR_FC_WR_COIL) ? mem_rd_data :
              (mem_rd_data[0] ? `MBR_COIL_ON : `MBR_COIL_OFF);
            state_reg <= S_PHI;
          end
        end
        S_PHI: begin
          if (f_push) begin
            state_reg <= S_PLO;
          end
        end
        S_PLO, S_PBYTE: begin
          if (f_push) begin
            acc_reg <= 8'h00;
            bit_reg <= 3'h0;
            timer_reg <= 26'h0000000;
            if (rem_reg != 11'h000) begin
              state_reg <= S_FETCH;
            end else if (slave_reg == 8'h00) begin
              state_reg <= S_IDLE;
              port_busy_flag_reg <= 1'b0;
            end else begin
              state_reg <= S_RECV;
            end
          end
        end
        S_RECV: begin
          timer_reg <= timer_reg + 26'h0000001;
          if (rsp_error || (timer_reg == TIMEOUT_LAST)) begin
            state_reg <= S_IDLE;
            port_busy_flag_reg <= 1'b0;
            port_comm_error_flag_reg <= 1'b1;
          end else if (slave_reg == 8'h00 && !write_reg) begin
            state_reg <= S_IDLE;
            port_busy_flag_reg <= 1'b0;
          end else if (rsp_valid) begin
            ridx_reg <= (ridx_reg == 9'h1FF) ? ridx_reg : ridx_reg + 9'h001;
            last_seen_reg <= rsp_last;
            if (ridx_reg == 9'h000) begin
              if (rsp_data != slave_reg) begin
                bad_reg <= 1'b1;
              end
            end else if (ridx_reg == 9'h001) begin
              if (rsp_data == (func_reg | `MBR_FC_EXC_BIT)) begin
                exc_seen_reg <= 1'b1;
                bad_reg <= 1'b1;
              end else if (rsp_data != func_reg) begin
                bad_reg <= 1'b1;
              end
            end else if (ridx_reg == 9'h002 && exc_seen_reg) begin
              mem_wr_reg <= 1'b1;
              mem_addr_reg <= exc_reg;
              mem_wdata_reg <= {func_reg | `MBR_FC_EXC_BIT, rsp_data};
            end else if (ridx_reg == 9'h002 && !write_reg &&
                         func_reg == `MBR_FC_RD_EXST && !bad_reg) begin
              mem_wr_reg <= 1'b1;
              mem_addr_reg <= mptr_reg;
              mem_wdata_reg <= {8'h00, rsp_data};
            end else if (ridx_reg >= 9'h003 && rd_data_mode && !bad_reg) begin
              if (bits_reg) begin
                rbyte_reg <= rsp_data;
                bit_reg <= 3'h0;
                state_reg <= S_UNPK;
              end else if (ridx_reg[0]) begin
                rbyte_reg <= rsp_data;
              end else if (rem_reg != 11'h000) begin
                mem_wr_reg <= 1'b1;
                mem_addr_reg <= mptr_reg;
                mem_wdata_reg <= {rbyte_reg, rsp_data};
                mptr_reg <= mptr_reg + 16'h0001;
                rem_reg <= rem_reg - 11'h001;
              end
            end
            if (rsp_last && !(ridx_reg >= 9'h003 && rd_data_mode && !bad_reg && bits_reg)) begin
              state_reg <= S_IDLE;
              port_busy_flag_reg <= 1'b0;
              port_comm_error_flag_reg <= finish_err || exc_seen_reg ||
                (ridx_reg == 9'h001 && rsp_data != func_reg) ||
                (ridx_reg == 9'h000);
            end
          end
        end
        S_UNPK: begin
          if (rem_reg != 11'h000) begin
            mem_wr_reg <= 1'b1;
            mem_addr_reg <= mptr_reg;
            mem_wdata_reg <= {15'h0000, rbyte_reg[bit_reg]};
            mptr_reg <= mptr_reg + 16'h0001;
            rem_reg <= rem_reg - 11'h001;
          end
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7 || rem_reg <= 11'h001) begin
            if (last_seen_reg) begin
              state_reg <= S_IDLE;
              port_busy_flag_reg <= 1'b0;
              port_comm_error_flag_reg <= bad_reg || (rem_reg > 11'h001);
            end else begin
              state_reg <= S_RECV;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          port_busy_flag_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/mrmr_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrmr_props #(
  parameter RSP_TIMEOUT_CYC = 200
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Request
  input wire req_valid,
  input wire req_is_write,
  input wire [7:0] req_slave,
  input wire [7:0] req_func,
  input wire req_fmt_484,
  input wire [19:0] req_slave_ref,
  input wire [10:0] req_count,
  // Flags and streams
  input wire port_busy_flag_reg,
  input wire port_comm_error_flag_reg,
  input wire tx_valid,
  input wire tx_ready,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire rsp_error,
  input wire mem_wr_reg
);
  wire busy = port_busy_flag_reg;
  wire err = port_comm_error_flag_reg;
  wire [7:0] fc = req_func;
  wire [10:0] cn = req_count;
  wire [19:0] rf = req_slave_ref;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take;
    req_valid && !busy;
  endsequence
  sequence s_start;
    busy && !err;
  endsequence
  property p_slave_range;
    s_take ##0 (req_slave > 8'hF7) |=> !busy && $stable(err);
  endproperty
  a_slave_range: assert property (p_slave_range) else $error("far station taken");
  property p_bad_read;
    s_take ##0 (!req_is_write && !(fc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07})) |=> !busy;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("bad read code taken");
  property p_bad_write;
    s_take ##0 (req_is_write && !(fc inside {8'h05, 8'h06, 8'h0F, 8'h10})) |=> !busy;
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("bad write code taken");
  property p_bad_count;
    s_take ##0 ((fc inside {8'h03, 8'h04, 8'h10} && (cn == 11'h000 || cn > 11'h07D)) ||
      (fc inside {8'h01, 8'h02, 8'h0F} && (cn == 11'h000 || cn > 11'h7D0))) |=> !busy;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count taken");
  property p_bad_ref;
    s_take ##0 (fc == 8'h03 && req_fmt_484 && rf > 20'h01387) |=> !busy;
  endproperty
  a_bad_ref: assert property (p_bad_ref) else $error("bad reference taken");
  property p_take_read;
    s_take ##0 (!req_is_write && fc == 8'h03 && !req_fmt_484 && req_slave <= 8'hF7 &&
      rf >= 20'h09C41 && rf <= 20'h0C34F && cn >= 11'h001 && cn <= 11'h07D) |=> s_start;
  endproperty
  a_take_read: assert property (p_take_read) else $error("read not started");
  property p_take_single;
    s_take ##0 (req_is_write && fc == 8'h06 && req_fmt_484 && req_slave <= 8'hF7 &&
      rf >= 20'h00FA1 && rf <= 20'h01387) |=> s_start;
  endproperty
  a_take_single: assert property (p_take_single) else $error("write not started");
  property p_err_quiet;
    !busy && !req_valid |=> $stable(err);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag moved idle");
  property p_mem_src;
    mem_wr_reg |-> busy || $fell(busy);
  endproperty
  a_mem_src: assert property (p_mem_src) else $error("memory write idle");
  property p_rsp_err;
    busy && rsp_error |=> ##[0:3] (!busy && err);
  endproperty
  a_rsp_err: assert property (p_rsp_err) else $error("framer error lost");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("stalled byte changed");
endmodule
bind mbreq_master mrmr_props #(.RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC)) u_mrmr_props (.*);
`default_nettype wire

// ==== tb/mrmr_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrmr_slave (
  // Clock
  input wire clock,
  // Request bytes from the master
  input wire tx_valid,
  output logic tx_ready,
  input wire [7:0] tx_data,
  input wire tx_last,
  // Reply bytes to the master
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic rsp_error
);
  logic [63:0] rx_vec = 64'h0;
  logic [63:0] rsp_vec = 64'h0;
  int rx_n = 0;
  int frames = 0;
  int served = 0;
  int rsp_len = 0;
  logic stall = 1'b0;
  logic bad = 1'b0;
  // A frame counts once its final byte is taken.
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      rx_vec <= {rx_vec[55:0], tx_data};
      rx_n <= rx_n + 1;
      frames <= frames + (tx_last ? 1 : 0);
    end
  end
  // Replies are spaced ten cycles apart and the data line flips between bytes.
  initial begin
    tx_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h5A;
    rsp_last = 1'b0;
    rsp_error = 1'b0;
    forever begin
      @(negedge clock);
      tx_ready = stall ? ~tx_ready : 1'b1;
      if (served != frames) begin
        served = frames;
        repeat (4) @(negedge clock);
        rsp_error = bad;
        @(negedge clock);
        rsp_error = 1'b0;
        for (int i = 0; i < rsp_len; i++) begin
          rsp_data = rsp_vec[8 * (rsp_len - 1 - i) +: 8];
          rsp_last = (i == rsp_len - 1);
          rsp_valid = 1'b1;
          @(negedge clock);
          rsp_valid = 1'b0;
          rsp_last = 1'b0;
          rsp_data = ~rsp_data;
          repeat (9) @(negedge clock);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/modbus_rtu_master_requests_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_master_requests_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_is_write = 1'b0;
  logic [7:0] req_slave = 8'h00;
  logic [7:0] req_func = 8'h00;
  logic req_fmt_484 = 1'b0;
  logic [19:0] req_slave_ref = 20'h00000;
  logic [15:0] req_master_addr = 16'h0000;
  logic [10:0] req_count = 11'h000;
  logic [15:0] req_exc_addr = 16'h0000;
  wire port_busy_flag_reg, port_comm_error_flag_reg, tx_valid, tx_ready, tx_last;
  wire rsp_valid, rsp_last, rsp_error, mem_rd_reg, mem_wr_reg;
  wire [7:0] tx_data, rsp_data;
  wire [15:0] mem_addr_reg, mem_wdata_reg, mem_rd_data;
  logic [15:0] mem [0:1023];
  int checks = 0;
  int mismatches = 0;
  assign mem_rd_data = mem[mem_addr_reg[9:0]];
  always @(posedge clock) if (mem_wr_reg) mem[mem_addr_reg[9:0]] <= mem_wdata_reg;
  mbreq_master #(.RSP_TIMEOUT_CYC(200)) u_mbreq_master (.*);
  mrmr_slave u_mrmr_slave (.*);
  initial forever #12.5 clock = ~clock;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic w, input logic [7:0] sl, input logic [7:0] fc,
      input logic f4, input logic [19:0] rf, input logic [10:0] cn);
    @(negedge clock);
    req_is_write = w;
    req_slave = sl;
    req_func = fc;
    req_fmt_484 = f4;
    req_slave_ref = rf;
    req_count = cn;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
  endtask
  task automatic arm(input logic [63:0] rv, input int rl, input logic st, input logic bd);
    u_mrmr_slave.rx_n = 0;
    u_mrmr_slave.rsp_vec = rv;
    u_mrmr_slave.rsp_len = rl;
    u_mrmr_slave.stall = st;
    u_mrmr_slave.bad = bd;
  endtask
  task automatic finish(input logic [63:0] fr, input int n, input logic e);
    int k;
    k = 0;
    while (port_busy_flag_reg !== 1'b0 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    chk(k < 3000, 1);
    chk(u_mrmr_slave.rx_n, n);
    chk(u_mrmr_slave.rx_vec & ((64'h1 << (8 * n)) - 64'h1), fr);
    chk(port_comm_error_flag_reg, e);
  endtask
  task automatic refuse(input logic w, input logic [7:0] sl, input logic [7:0] fc,
      input logic f4, input logic [19:0] rf, input logic [10:0] cn);
    logic e;
    e = port_comm_error_flag_reg;
    u_mrmr_slave.rx_n = 0;
    issue(w, sl, fc, f4, rf, cn);
    repeat (4) @(negedge clock);
    chk(port_busy_flag_reg, 0);
    chk(port_comm_error_flag_reg, e);
    chk(u_mrmr_slave.rx_n, 0);
  endtask
  task automatic t_read_regs;
    req_master_addr = 16'h0064;
    arm(56'h01030412345678, 7, 1, 0);
    issue(0, 8'h01, 8'h03, 0, 20'h09C43, 11'h002);
    chk(port_busy_flag_reg, 1);
    issue(0, 8'h02, 8'h04, 0, 20'h07531, 11'h001);
    chk(port_busy_flag_reg, 1);
    finish(48'h010300020002, 6, 0);
    chk(mem[100], 16'h1234);
    chk(mem[101], 16'h5678);
    $display("read_regs done");
  endtask
  task automatic t_read_bits;
    req_master_addr = 16'h012C;
    mem[301] = 16'hFFFF;
    arm(32'h05020105, 4, 0, 0);
    issue(0, 8'h05, 8'h02, 0, 20'h186A3, 11'h003);
    finish(48'h050200020003, 6, 0);
    chk(mem[300][0], 1);
    chk(mem[301][0], 0);
    chk(mem[302][0], 1);
    $display("read_bits done");
  endtask
  task automatic t_write_exc;
    req_master_addr = 16'h00C8;
    req_exc_addr = 16'h0190;
    mem[200] = 16'hABCD;
    arm(24'h078602, 3, 0, 0);
    issue(1, 8'h07, 8'h06, 1, 20'h00FA2, 11'h000);
    finish(48'h07060001ABCD, 6, 1);
    chk(mem[400], 16'h8602);
    $display("write_exc done");
  endtask
  task automatic t_status;
    arm(24'h09075A, 3, 0, 0);
    issue(0, 8'h09, 8'h07, 1, 20'h00000, 11'h000);
    chk(port_comm_error_flag_reg, 0);
    finish(16'h0907, 2, 0);
    $display("status done");
  endtask
  task automatic t_faults;
    arm(64'h0, 0, 0, 0);
    issue(0, 8'h03, 8'h04, 0, 20'h07535, 11'h001);
    finish(48'h030400040001, 6, 1);
    req_master_addr = 16'h01F4;
    mem[500] = 16'h0001;
    mem[501] = 16'h0000;
    arm(64'h0, 0, 0, 1);
    issue(1, 8'h04, 8'h0F, 1, 20'h00003, 11'h002);
    finish(64'h040F000200020101, 8, 1);
    $display("faults done");
  endtask
  task automatic t_refused;
    refuse(0, 8'hF8, 8'h03, 0, 20'h09C41, 11'h001);
    refuse(0, 8'h01, 8'h05, 0, 20'h00001, 11'h001);
    refuse(1, 8'h01, 8'h03, 0, 20'h09C41, 11'h001);
    refuse(0, 8'h01, 8'h03, 0, 20'h09C41, 11'h07E);
    refuse(0, 8'h01, 8'h01, 0, 20'h00001, 11'h7D1);
    refuse(1, 8'h01, 8'h10, 0, 20'h09C41, 11'h000);
    refuse(0, 8'h01, 8'h03, 1, 20'h09C41, 11'h001);
    refuse(0, 8'h01, 8'h01, 1, 20'h003E8, 11'h001);
    refuse(0, 8'h01, 8'h02, 1, 20'h007D0, 11'h001);
    refuse(0, 8'h01, 8'h03, 1, 20'h01388, 11'h001);
    refuse(0, 8'h01, 8'h04, 0, 20'h07530, 11'h001);
    $display("refused done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    for (int a = 0; a < 1024; a++) mem[a] = 16'h0000;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_read_regs();
    t_read_bits();
    t_write_exc();
    t_status();
    t_faults();
    t_refused();
    wrap_up();
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
